/* File: hdl/wdl_wake_detect.sv */
// Purpose: Wake output, sticky detect events and their registers behind an APB slave.
// Assumes: Detect event inputs are one-cycle pulses synchronous to clk.
// Notes: One wait state on every APB access; unmapped addresses answer with pslverr.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module wdl_wake_detect (
  input wire logic clk, // Internal master clock
  input wire logic rst_b, // Async reset, low active
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [15:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic bias_sense_state, // Live headset bias sense level
  input wire logic plug_event_flag, // Plug detect pulse
  input wire logic unplug_event_flag, // Unplug detect pulse
  input wire logic button_press_event, // Mic button_press_event pulse
  input wire logic button_release_event, // Mic short released pulse
  input wire logic level_fall_event, // Level detect true to false pulse
  input wire logic level_rise_event, // Level detect false to true pulse
  output logic wake_b, // Wake output, low active
  output logic irq, // Interrupt, high active level
  output logic fs_tick, // Internal sample-rate tick
  output logic [7:0] power_down, // Power-down control bits
  output logic [5:0] level_detect_percent // Detect level setting
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int EW = wdl_pkg::EV_W;
  logic [7:0] clk_ctrl_q, clk_ctrl_d;
  logic [7:0] pdn_q, pdn_d;
  logic [7:0] wake_ctrl_q, wake_ctrl_d;
  logic [7:0] mic_det_q, mic_det_d;
  logic [EW-1:0] irq_mask_q, irq_mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic wake_lat_q, wake_lat_d;
  logic wake_b_q, wake_b_d;
  logic irq_q, irq_d;
  logic fs_tick_q;
  logic [EW-1:0] ev;
  logic [EW-1:0] stby_q;
  logic [EW-1:0] core_q;
  logic [EW-1:0] irq_st_q;
  logic [EW-1:0] stby_set;
  logic [EW-1:0] core_set;
  logic [EW-1:0] core_clr;
  logic [EW-1:0] irq_clr;
  logic [EW-1:0] shown;
  logic done;
  logic wr;
  logic rd;
  logic hit;
  logic copy_stby;
  logic evt_sel;
  logic trig;
  logic [7:0] stat_one;
  logic [7:0] stat_two;

  wdl_rate_if rif ();

  // ----------------------------------------
  // Event gathering
  // ----------------------------------------
  always_comb begin
    ev = '0;
    ev[wdl_pkg::EV_PLUG] = plug_event_flag;
    ev[wdl_pkg::EV_UNPLUG] = unplug_event_flag;
    ev[wdl_pkg::EV_PRESS] = button_press_event;
    ev[wdl_pkg::EV_RELEASE] = button_release_event;
    ev[wdl_pkg::EV_FALL] = level_fall_event;
    ev[wdl_pkg::EV_RISE] = level_rise_event;
  end

  assign copy_stby = mic_det_q[wdl_pkg::COPY_STBY_BIT];
  assign evt_sel = mic_det_q[wdl_pkg::EVT_SEL_BIT];
  assign stby_set = copy_stby ? '0 : ev;
  assign core_set = evt_sel ? stby_q : '0;

  // Standby latches survive core power loss; restored from core copy on request
  wdl_sticky #(.W(EW)) u_stby (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .set(stby_set),
    .clr('0),
    .load(copy_stby),
    .load_val(core_q),
    .q(stby_q)
  );

  // Core-domain processed copy; the standby set beats the clear from reading its status register
  wdl_sticky #(.W(EW)) u_core (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .set(core_set),
    .clr(core_clr),
    .load(1'b0),
    .load_val('0),
    .q(core_q)
  );

  wdl_sticky #(.W(EW)) u_irq (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .set(ev),
    .clr(irq_clr),
    .load(1'b0),
    .load_val('0),
    .q(irq_st_q)
  );

  assign rif.rate_sel = clk_ctrl_q[wdl_pkg::RATE_SEL_BIT];

  wdl_rate_div u_div (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .rif(rif)
  );

  // ----------------------------------------
  // Status views
  // ----------------------------------------
  always_comb begin
    shown = evt_sel ? core_q : ev;
    stat_one = 8'h00;
    stat_one[7] = bias_sense_state;
    stat_one[6] = shown[wdl_pkg::EV_PLUG];
    stat_one[5] = shown[wdl_pkg::EV_UNPLUG];
    stat_two = 8'h00;
    stat_two[7] = shown[wdl_pkg::EV_FALL];
    stat_two[6] = shown[wdl_pkg::EV_RISE];
    stat_two[5] = shown[wdl_pkg::EV_RELEASE];
    stat_two[4] = shown[wdl_pkg::EV_PRESS];
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign done = psel & penable & pready_q;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;

  always_comb begin
    case (paddr)
      wdl_pkg::ADDR_CLK_CTRL,
      wdl_pkg::ADDR_PDN_ONE,
      wdl_pkg::ADDR_STAT_ONE,
      wdl_pkg::ADDR_STAT_TWO,
      wdl_pkg::ADDR_IRQ_STAT,
      wdl_pkg::ADDR_IRQ_MASK,
      wdl_pkg::ADDR_WAKE_CTRL,
      wdl_pkg::ADDR_MIC_DET: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read-to-clear only touches the bits that register shows
  always_comb begin
    core_clr = '0;
    irq_clr = '0;
    if (rd && evt_sel && paddr == wdl_pkg::ADDR_STAT_ONE) begin
      core_clr[wdl_pkg::EV_PLUG] = 1'b1;
      core_clr[wdl_pkg::EV_UNPLUG] = 1'b1;
    end
    if (rd && evt_sel && paddr == wdl_pkg::ADDR_STAT_TWO) begin
      core_clr[wdl_pkg::EV_FALL] = 1'b1;
      core_clr[wdl_pkg::EV_RISE] = 1'b1;
      core_clr[wdl_pkg::EV_RELEASE] = 1'b1;
      core_clr[wdl_pkg::EV_PRESS] = 1'b1;
    end
    if (wr && paddr == wdl_pkg::ADDR_IRQ_STAT) begin
      irq_clr = pwdata[EW-1:0];
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    clk_ctrl_d = clk_ctrl_q;
    pdn_d = pdn_q;
    wake_ctrl_d = wake_ctrl_q;
    mic_det_d = mic_det_q;
    irq_mask_d = irq_mask_q;
    if (wr) begin
      case (paddr)
        wdl_pkg::ADDR_CLK_CTRL: clk_ctrl_d = pwdata[7:0] & wdl_pkg::CLK_WMASK;
        wdl_pkg::ADDR_PDN_ONE: pdn_d = pwdata[7:0] & wdl_pkg::PDN_WMASK;
        wdl_pkg::ADDR_WAKE_CTRL: wake_ctrl_d = pwdata[7:0] & wdl_pkg::WAKE_WMASK;
        wdl_pkg::ADDR_MIC_DET: mic_det_d = pwdata[7:0];
        wdl_pkg::ADDR_IRQ_MASK: irq_mask_d = pwdata[EW-1:0];
        default: clk_ctrl_d = clk_ctrl_q;
      endcase
    end
  end

  always_comb begin
    pready_d = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~hit;
    prdata_d = prdata_q;
    if (pready_d) begin
      case (paddr)
        wdl_pkg::ADDR_CLK_CTRL: prdata_d = {24'h000000, clk_ctrl_q};
        wdl_pkg::ADDR_PDN_ONE: prdata_d = {24'h000000, pdn_q};
        wdl_pkg::ADDR_STAT_ONE: prdata_d = {24'h000000, stat_one};
        wdl_pkg::ADDR_STAT_TWO: prdata_d = {24'h000000, stat_two};
        wdl_pkg::ADDR_IRQ_STAT: prdata_d = {26'h0000000, irq_st_q};
        wdl_pkg::ADDR_IRQ_MASK: prdata_d = {26'h0000000, irq_mask_q};
        wdl_pkg::ADDR_WAKE_CTRL: prdata_d = {24'h000000, wake_ctrl_q};
        wdl_pkg::ADDR_MIC_DET: prdata_d = {24'h000000, mic_det_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Wake and interrupt outputs
  // ----------------------------------------
  always_comb begin
    trig = (ev[wdl_pkg::EV_PRESS] & ~wake_ctrl_q[wdl_pkg::MIC_WAKE_MASK_BIT])
      | ((ev[wdl_pkg::EV_PLUG] | ev[wdl_pkg::EV_UNPLUG])
      & ~wake_ctrl_q[wdl_pkg::PLUG_WAKE_MASK_BIT]);
    if (wake_ctrl_q[wdl_pkg::WAKE_RELEASE_BIT]) begin
      wake_lat_d = 1'b0;
    end else if (!wake_ctrl_q[wdl_pkg::WAKE_BEHAV_BIT]) begin
      wake_lat_d = wake_lat_q | trig;
    end else begin
      wake_lat_d = trig;
    end
    wake_b_d = ~wake_lat_d;
    irq_d = |(irq_st_q & irq_mask_q);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_ctrl_q <= wdl_pkg::CLK_CTRL_RST;
      pdn_q <= wdl_pkg::PDN_ONE_RST;
      wake_ctrl_q <= wdl_pkg::WAKE_CTRL_RST;
      mic_det_q <= wdl_pkg::MIC_DET_RST;
      irq_mask_q <= wdl_pkg::IRQ_MASK_RST;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      wake_lat_q <= 1'b0;
      wake_b_q <= 1'b1;
      irq_q <= 1'b0;
      fs_tick_q <= 1'b0;
    end else if (ce) begin
      clk_ctrl_q <= clk_ctrl_d;
      pdn_q <= pdn_d;
      wake_ctrl_q <= wake_ctrl_d;
      mic_det_q <= mic_det_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      wake_lat_q <= wake_lat_d;
      wake_b_q <= wake_b_d;
      irq_q <= irq_d;
      fs_tick_q <= rif.fs_tick;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wake_b = wake_b_q;
  assign irq = irq_q;
  assign fs_tick = fs_tick_q;
  assign power_down = pdn_q;
  assign level_detect_percent = mic_det_q[5:0];
endmodule : wdl_wake_detect

/* File: shared/wdl_pkg.sv */
// Purpose: Constants and register layout for the wake and detect-event latch block.
// Assumes: APB with 32-bit data; register indices times four give byte addresses.
// Notes:
package wdl_pkg;
  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam int IDX_CLK_CTRL = 'h1009;
  localparam int IDX_PDN_ONE = 'h1101;
  localparam int IDX_STAT_ONE = 'h1309;
  localparam int IDX_STAT_TWO = 'h130A;
  localparam int IDX_IRQ_STAT = 'h1320;
  localparam int IDX_IRQ_MASK = 'h1321;
  localparam int IDX_WAKE_CTRL = 'h1B71;
  localparam int IDX_MIC_DET = 'h1B75;
  localparam logic [15:0] ADDR_CLK_CTRL = 16'(IDX_CLK_CTRL * 4);
  localparam logic [15:0] ADDR_PDN_ONE = 16'(IDX_PDN_ONE * 4);
  localparam logic [15:0] ADDR_STAT_ONE = 16'(IDX_STAT_ONE * 4);
  localparam logic [15:0] ADDR_STAT_TWO = 16'(IDX_STAT_TWO * 4);
  localparam logic [15:0] ADDR_IRQ_STAT = 16'(IDX_IRQ_STAT * 4);
  localparam logic [15:0] ADDR_IRQ_MASK = 16'(IDX_IRQ_MASK * 4);
  localparam logic [15:0] ADDR_WAKE_CTRL = 16'(IDX_WAKE_CTRL * 4);
  localparam logic [15:0] ADDR_MIC_DET = 16'(IDX_MIC_DET * 4);

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RATE_SEL_BIT = 1;
  localparam int MIC_WAKE_MASK_BIT = 7;
  localparam int PLUG_WAKE_MASK_BIT = 6;
  localparam int WAKE_BEHAV_BIT = 5;
  localparam int WAKE_RELEASE_BIT = 0;
  localparam int COPY_STBY_BIT = 7;
  localparam int EVT_SEL_BIT = 6;
  localparam int GLOBAL_PDN_BIT = 0;
  // Event vector order, also the interrupt status layout
  localparam int EV_PLUG = 0;
  localparam int EV_UNPLUG = 1;
  localparam int EV_PRESS = 2;
  localparam int EV_RELEASE = 3;
  localparam int EV_FALL = 4;
  localparam int EV_RISE = 5;
  localparam int EV_W = 6;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] CLK_CTRL_RST = 8'h00;
  localparam logic [7:0] PDN_ONE_RST = 8'hFF;
  localparam logic [7:0] WAKE_CTRL_RST = 8'h00;
  localparam logic [7:0] MIC_DET_RST = 8'h1F;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 6'h00;
  localparam logic [7:0] PDN_WMASK = 8'hFD;
  localparam logic [7:0] WAKE_WMASK = 8'hE1;
  localparam logic [7:0] CLK_WMASK = 8'h02;
  localparam int RATE_DIV_BASE = 250;
  localparam int RATE_DIV_ALT = 256;
  localparam int RATE_CNT_W = 9;
endpackage : wdl_pkg

/* File: shared/wdl_rate_if.sv */
// Purpose: Carries the sample-rate select and tick between controller and divider.
// Assumes: Single clock domain.
// Notes: Tick is a one-cycle pulse.
`timescale 1ns/1ps
interface wdl_rate_if;
  logic rate_sel;
  logic fs_tick;
  modport ctl (output rate_sel, input fs_tick);
  modport div (input rate_sel, output fs_tick);
endinterface : wdl_rate_if

/* File: hdl/wdl_sticky.sv */
// Purpose: Bank of sticky bits with set, clear and parallel load.
// Assumes: Set beats clear in the same cycle; load beats both.
// Notes: Shared by the standby latches, core copies and interrupt status.
`timescale 1ns/1ps
module wdl_sticky #(
  parameter int W = 6
) (
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset, low active
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] set, // Set pulses
  input wire logic [W-1:0] clr, // Clear pulses
  input wire logic load, // Parallel load strobe
  input wire logic [W-1:0] load_val, // Parallel load value
  output logic [W-1:0] q // Sticky state
);
  logic [W-1:0] q_d;

  always_comb begin
    if (load) begin
      q_d = load_val;
    end else begin
      q_d = (q & ~clr) | set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= q_d;
    end
  end
endmodule : wdl_sticky

/* File: hdl/wdl_rate_div.sv */
// Purpose: Derives the internal sample-rate tick from the internal master clock.
// Assumes: clk is the internal master clock.
// Notes: Changing the select restarts nothing; the count just wraps at the new length.
`timescale 1ns/1ps
module wdl_rate_div (
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset, low active
  input wire logic ce, // Clock enable
  wdl_rate_if.div rif // Select in, tick out
);
  localparam logic [wdl_pkg::RATE_CNT_W-1:0] LAST_BASE = wdl_pkg::RATE_CNT_W'(wdl_pkg::RATE_DIV_BASE - 1);
  localparam logic [wdl_pkg::RATE_CNT_W-1:0] LAST_ALT = wdl_pkg::RATE_CNT_W'(wdl_pkg::RATE_DIV_ALT - 1);
  logic [wdl_pkg::RATE_CNT_W-1:0] cnt_q;
  logic [wdl_pkg::RATE_CNT_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic [wdl_pkg::RATE_CNT_W-1:0] last;

  always_comb begin
    last = rif.rate_sel ? LAST_ALT : LAST_BASE;
    if (cnt_q >= last) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign rif.fs_tick = tick_q;
endmodule : wdl_rate_div

/* File: bench/wdl_chk.sv */
// Purpose: Port-level checks for the wake and detect-event block.
// Assumes: ce held high.
// Notes: Register state is shadowed by snooping completed APB writes.
`timescale 1ns/1ps
module wdl_chk (
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset, low active
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [15:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic plug_event_flag, // Plug pulse
  input wire logic wake_b, // Wake, low active
  input wire logic irq, // Interrupt
  input wire logic fs_tick // Rate tick
);
  logic [7:0] wake_q, wake_d;
  logic [5:0] mask_q, mask_d;
  logic [8:0] cnt_q, cnt_d;
  logic rate_q, rate_d, chg_q, chg_d, seen_q, seen_d, wr, clk_wr, rel_wr;
  // ----------------------------------------
  // Shadow registers
  // ----------------------------------------
  always_comb begin
    wr = psel && penable && pready && pwrite;
    clk_wr = wr && paddr == wdl_pkg::ADDR_CLK_CTRL;
    rel_wr = wr && paddr == wdl_pkg::ADDR_WAKE_CTRL && pwdata[0];
    wake_d = (wr && paddr == wdl_pkg::ADDR_WAKE_CTRL) ? pwdata[7:0] : wake_q;
    mask_d = (wr && paddr == wdl_pkg::ADDR_IRQ_MASK) ? pwdata[5:0] : mask_q;
    rate_d = clk_wr ? pwdata[1] : rate_q;
    chg_d = clk_wr || (chg_q && !fs_tick);
    seen_d = seen_q || fs_tick;
    cnt_d = fs_tick ? 9'h000 : cnt_q + 9'h001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_q <= 8'h00;
      mask_q <= 6'h00;
      cnt_q <= 9'h000;
      {rate_q, chg_q, seen_q} <= 3'h0;
    end else begin
      wake_q <= wake_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      {rate_q, chg_q, seen_q} <= {rate_d, chg_d, seen_d};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  apb_wait_a: assert property (psel && penable && !pready && !$past(penable) |=> pready)
    else $error("APB answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  wake_trig_a: assert property (plug_event_flag && !wake_q[6] && !wake_q[0] |=> !wake_b)
    else $error("Unmasked plug did not assert wake");
  wake_hold_a: assert property (!wake_b && !wake_q[5] && !wake_q[0] && !rel_wr |=> !wake_b)
    else $error("Latched wake released without clear");
  wake_release_a: assert property (rel_wr |-> ##2 wake_b) else $error("Wake clear did not deassert");
  release_hold_a: assert property (wake_q[0] |=> wake_b) else $error("Wake low while clear set");
  wake_mask_a: assert property (wake_b && wake_q[7] && wake_q[6] |=> wake_b) else $error("Masked wake fired");
  irq_event_a: assert property (plug_event_flag && mask_q[0] |-> ##2 irq) else $error("Enabled event no irq");
  irq_off_a: assert property (mask_q == 6'h00 |=> !irq) else $error("irq with all sources masked");
  tick_gap_a: assert property (fs_tick && seen_q && !chg_q |->
    cnt_q == (rate_q ? 9'(wdl_pkg::RATE_DIV_ALT - 1) : 9'(wdl_pkg::RATE_DIV_BASE - 1)))
    else $error("Rate tick spacing wrong");
  cover property ($fell(wake_b));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule : wdl_chk

bind wdl_wake_detect wdl_chk wdl_chk_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .plug_event_flag, .wake_b, .irq, .fs_tick);

/* File: bench/wdl_host_model.sv */
// Purpose: Host that runs single APB transfers for the bench.
// Assumes: Slave answers in its own time; only the bench watchdog ends a wait.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/1ps
module wdl_host_model (
  input wire logic clk, // Clock
  output logic psel, // APB select
  output logic penable, // APB enable
  output logic pwrite, // APB direction
  output logic [15:0] paddr, // APB address
  output logic [31:0] pwdata, // APB write data
  input wire logic pready // APB ready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end
  // ----------------------------------------
  // One transfer, held until pready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : wdl_host_model

/* File: bench/tb_wdl_wake_detect.sv */
// Purpose: Self-checking bench for the wake and detect-event block.
// Assumes: ce held high; 40 MHz clock.
// Notes: Reads queue their expectation; a monitor compares on pready.
`timescale 1ns/1ps
module tb_wdl_wake_detect;
  logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, bias, wake_b, irq, fs_tick;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] ev, acc, v, lvl;
  logic [7:0] pdn;
  logic [32:0] exp_q[$];
  int num_errors = 0;
  int num_checks = 0;
  int gap;

  wdl_host_model wdl_host_model_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready));
  wdl_wake_detect wdl_wake_detect_i (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bias_sense_state(bias), .plug_event_flag(ev[0]), .unplug_event_flag(ev[1]),
    .button_press_event(ev[2]), .button_release_event(ev[3]), .level_fall_event(ev[4]),
    .level_rise_event(ev[5]), .wake_b(wake_b), .irq(irq), .fs_tick(fs_tick), .power_down(pdn),
    .level_detect_percent(lvl));

  // Master clock stands in for the host-supplied reference
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // Compare, report, bus tasks
  // ----------------------------------------
  task automatic check_out(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_out
  task automatic check_rd(input logic [32:0] exp);
    check_out({pslverr, prdata}, exp);
  endtask : check_rd
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic rd(input logic [15:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    wdl_host_model_i.xfer(1'b0, a, 32'h00000000);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    wdl_host_model_i.xfer(1'b1, a, d);
  endtask : wr
  task automatic pulse(input logic [5:0] p);
    @(posedge clk);
    ev <= p;
    acc = acc | p;
    @(posedge clk);
    ev <= 6'h00;
  endtask : pulse
  task automatic tick_gap(output int n);
    int k;
    k = 0;
    n = 0;
    while (fs_tick !== 1'b1 && k < 600) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    while (fs_tick !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
  endtask : tick_gap

  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
      check_rd(exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("Watchdog expired");
    stop_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(60053));
    bias = 1'($urandom);
    ce = 1'b1;
    rst_b = 1'b0;
    ev = 6'h00;
    acc = 6'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(wdl_pkg::ADDR_CLK_CTRL, 33'h0);
    rd(wdl_pkg::ADDR_PDN_ONE, 33'hFF);
    rd(wdl_pkg::ADDR_WAKE_CTRL, 33'h0);
    rd(wdl_pkg::ADDR_MIC_DET, 33'h1F);
    rd(wdl_pkg::ADDR_IRQ_MASK, 33'h0);
    check_out(33'(lvl), 33'h1F);
    rd(16'h0000, {1'b1, 32'h0});
    tick_gap(gap);
    check_out(33'(gap), 33'(wdl_pkg::RATE_DIV_BASE - 1));
    wr(wdl_pkg::ADDR_CLK_CTRL, 32'h2);
    tick_gap(gap);
    tick_gap(gap);
    check_out(33'(gap), 33'(wdl_pkg::RATE_DIV_ALT - 1));
    wr(wdl_pkg::ADDR_CLK_CTRL, 32'h0);
    wr(wdl_pkg::ADDR_WAKE_CTRL, 32'hC0);
    pulse(6'h07);
    repeat (3) @(posedge clk);
    check_out(33'(wake_b), 33'h1);
    wr(wdl_pkg::ADDR_WAKE_CTRL, 32'h00);
    pulse(6'h01);
    repeat (20) @(posedge clk);
    check_out(33'(wake_b), 33'h0);
    wr(wdl_pkg::ADDR_WAKE_CTRL, 32'hC1);
    repeat (3) @(posedge clk);
    check_out(33'(wake_b), 33'h1);
    wr(wdl_pkg::ADDR_WAKE_CTRL, 32'h40);
    pulse(6'h04);
    repeat (3) @(posedge clk);
    check_out(33'(wake_b), 33'h0);
    v = 6'($urandom);
    pulse(v);
    wr(wdl_pkg::ADDR_MIC_DET, 32'h5F);
    wr(wdl_pkg::ADDR_STAT_ONE, 32'h00);
    repeat (3) @(posedge clk);
    rd(wdl_pkg::ADDR_STAT_ONE, 33'({bias, acc[0], acc[1], 5'h00}));
    rd(wdl_pkg::ADDR_STAT_TWO, 33'({acc[4], acc[5], acc[3], acc[2], 4'h0}));
    rd(wdl_pkg::ADDR_IRQ_STAT, 33'(acc));
    check_out(33'(irq), 33'h0);
    wr(wdl_pkg::ADDR_IRQ_MASK, 32'h3F);
    repeat (3) @(posedge clk);
    check_out(33'(irq), 33'h1);
    wr(wdl_pkg::ADDR_IRQ_STAT, 32'(acc));
    repeat (3) @(posedge clk);
    check_out(33'(irq), 33'h0);
    rd(wdl_pkg::ADDR_IRQ_STAT, 33'h0);
    pulse(6'h01);
    repeat (3) @(posedge clk);
    check_out(33'(irq), 33'h1);
    wr(wdl_pkg::ADDR_MIC_DET, 32'h9F);
    rd(wdl_pkg::ADDR_MIC_DET, 33'h9F);
    rd(wdl_pkg::ADDR_STAT_ONE, 33'({bias, 7'h00}));
    wr(wdl_pkg::ADDR_PDN_ONE, 32'hFE);
    rd(wdl_pkg::ADDR_PDN_ONE, 33'hFC);
    repeat (3) @(posedge clk);
    check_out(33'(pdn), 33'hFC);
    // Pulse mode: wake low for one cycle per trigger only
    wr(wdl_pkg::ADDR_WAKE_CTRL, 32'h20);
    repeat (3) @(posedge clk);
    check_out(33'(wake_b), 33'h1);
    pulse(6'h01);
    @(posedge clk);
    check_out(33'(wake_b), 33'h0);
    @(posedge clk);
    check_out(33'(wake_b), 33'h1);
    check_out(33'(exp_q.size()), 33'h0);
    stop_test();
  end
endmodule : tb_wdl_wake_detect
